// >>> inc/port_regs_defs.vh
`ifndef PORT_REGS_DEFS_VH
`define PORT_REGS_DEFS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_INTERRUPT_MASK 6'h07
`define ADDR_LINK_SYNC_STATUS_HUNT 6'h08
`define ADDR_SYNC_PACKET_SEND_SELECT 6'h09
`define ADDR_CRC_ERROR_PORT_FLAGS 6'h0A
// ----------------------------------------
// Mask bit positions
// ----------------------------------------
`define MASK_BIT_BUS_PARITY 0
`define MASK_BIT_QUEUE_EMPTY 1
`define MASK_BIT_MEM_FULL 2
`define MASK_BIT_CRC_ERROR 5
`define MASK_BIT_ADDR_CORRUPT 6
`define MASK_BIT_MS_PARITY 7
`define MASK_BIT_CTRL_RECEIVED 8
`define MASK_BIT_CTRL_SENT 9
`define MASK_BIT_PROC_ERROR 10
`define MASK_BIT_SYNC 11
`define MASK_BIT_LOSS_OF_SIGNAL 12
`define MASK_BIT_FLOW_VIOLATION 13
// Implemented mask bits; 3, 4, 14, 15 reserved
`define MASK_WRITABLE 16'h3FE7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESET_INTERRUPT_MASK 16'h0000
`define RESET_SYNC_SEND_SELECT 16'h0000
`define RESET_CRC_FLAGS 16'h0000
`endif

// >>> rtl/sync_slot.v
`default_nettype none
// ----------------------------------------
// Per-port sync status with hunt request
// ----------------------------------------
module sync_slot (
  input wire core_clk, // system clock
  input wire rst_n, // sync reset, active low
  input wire clk_en, // freezes state while low
  input wire hunt_write, // write with this port's bit at one
  input wire link_locked, // link alignment achieved (already synchronised)
  output reg hunt_start, // one-cycle hunt request to alignment logic
  output reg synced // readable status
);
  always @(posedge core_clk) begin
    if (!rst_n) begin
      hunt_start <= 1'b0;
      synced <= 1'b0;
    end else if (clk_en) begin
      hunt_start <= hunt_write;
      if (hunt_write) begin
        synced <= 1'b0;
      end else if (!hunt_start) begin
        synced <= link_locked;
      end
    end
  end
endmodule // sync_slot
`default_nettype wire

// >>> rtl/port_flush_ctrl.v
`default_nettype none
// ----------------------------------------
// Per-output traffic steering under sync-packet mode
// ----------------------------------------
module port_flush_ctrl (
  input wire sync_send, // output sends sync packets
  input wire not_synced, // link unsynchronised
  input wire downstream_send_permission, // grant from downstream
  input wire threshold_grant, // occupancy vs threshold result
  output wire send_sync_packet, // send sync packets instead of traffic
  output wire slow_flush, // drain queue at data rate
  output wire dequeue_allowed, // dequeue may proceed
  output wire accept_input, // inputs keep accepting for this output
  output wire queue_grant // queue grant advertised
);
  assign send_sync_packet = sync_send;
  assign slow_flush = sync_send | not_synced;
  assign dequeue_allowed = slow_flush | downstream_send_permission;
  assign accept_input = 1'b1;
  assign queue_grant = threshold_grant;
endmodule // port_flush_ctrl
`default_nettype wire

// >>> rtl/switch_port_sync_and_irq_mask_regs.v
// Operation
// - Masked events still set status but raise no interrupt.
// - Mask bit 0 bus parity, 1 queue empty, 2 memory full; 3-4 reserved.
// - Bits 5 CRC, 6 address corruption, 7 parity, 8-9 control, 10 processor.
// - Bit 11 sync, 12 loss of signal, 13 flow violation; 14-15 reserved.
// - Sync register read: 0 unsynchronised with slow flush, 1 synchronised.
// - Writing one to a sync bit starts a hunt; zeros do nothing.
// - Starting a hunt drops that port's sync status to zero.
// - Per-port registers map bit n to port n, ports 0 to 15.
// - Selected outputs send sync packets instead of normal traffic.
// - Sync-sending outputs slow-flush at data rate, ignoring downstream grant.
// - Queue grants still come from threshold comparison.
// - CRC flag bit n sets when input port n sees a CRC error.
// - Reading CRC flags clears them after returning the value.
`include "port_regs_defs.vh"
`default_nettype none
module switch_port_sync_and_irq_mask_regs #(
  parameter PORTS = 16
) (
  input wire core_clk, // system clock, 50 MHz
  input wire rst_n, // sync reset, active low
  input wire clk_en, // freezes state while low
  input wire [5:0] config_bus_addr, // register address
  input wire config_bus_wr, // write strobe
  input wire config_bus_rd, // read strobe
  input wire [15:0] config_bus_wdata, // write data
  output reg [15:0] config_bus_rdata, // read data, registered
  output reg config_bus_rvalid, // read data valid
  input wire [15:0] app_status, // application status bits
  output wire interrupt_out, // interrupt request, active high
  input wire [PORTS-1:0] link_locked, // per-port alignment achieved
  output wire [PORTS-1:0] hunt_start, // per-port hunt pulse
  input wire [PORTS-1:0] crc_error, // per-port CRC error pulse
  input wire [PORTS-1:0] downstream_send_permission, // per-output downstream grant
  input wire [PORTS-1:0] threshold_grant, // per-output threshold compare
  output wire [PORTS-1:0] send_sync_packet, // per-output sync packet mode
  output wire [PORTS-1:0] slow_flush, // per-output slow flush
  output wire [PORTS-1:0] dequeue_allowed, // per-output dequeue enable
  output wire [PORTS-1:0] accept_input, // per-output input acceptance
  output wire [PORTS-1:0] queue_grant // per-output queue grant
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] interrupt_mask;
  reg [PORTS-1:0] sync_packet_send_select;
  reg [PORTS-1:0] crc_error_port_flags;
  wire [PORTS-1:0] synced;
  wire wr_mask = config_bus_wr && config_bus_addr == `ADDR_INTERRUPT_MASK;
  wire wr_sync = config_bus_wr && config_bus_addr == `ADDR_LINK_SYNC_STATUS_HUNT;
  wire wr_send = config_bus_wr && config_bus_addr == `ADDR_SYNC_PACKET_SEND_SELECT;
  wire rd_crc = config_bus_rd && config_bus_addr == `ADDR_CRC_ERROR_PORT_FLAGS;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      interrupt_mask <= `RESET_INTERRUPT_MASK;
      sync_packet_send_select <= `RESET_SYNC_SEND_SELECT;
      crc_error_port_flags <= `RESET_CRC_FLAGS;
    end else if (clk_en) begin
      if (wr_mask) begin
        interrupt_mask <= config_bus_wdata & `MASK_WRITABLE;
      end
      if (wr_send) begin
        sync_packet_send_select <= config_bus_wdata[PORTS-1:0];
      end
      // New errors win over the read clear
      crc_error_port_flags <= (rd_crc ? {PORTS{1'b0}} : crc_error_port_flags) | crc_error;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      config_bus_rdata <= 16'h0000;
      config_bus_rvalid <= 1'b0;
    end else if (clk_en) begin
      config_bus_rvalid <= config_bus_rd;
      if (config_bus_rd) begin
        case (config_bus_addr)
          `ADDR_INTERRUPT_MASK: config_bus_rdata <= interrupt_mask;
          `ADDR_LINK_SYNC_STATUS_HUNT: config_bus_rdata <= synced;
          `ADDR_SYNC_PACKET_SEND_SELECT: config_bus_rdata <= sync_packet_send_select;
          `ADDR_CRC_ERROR_PORT_FLAGS: config_bus_rdata <= crc_error_port_flags;
          default: config_bus_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Masked status stays visible upstream, only the request is gated
  assign interrupt_out = |(app_status & ~interrupt_mask & `MASK_WRITABLE);

  // ----------------------------------------
  // Per-port slices
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < PORTS; i = i + 1) begin : g_port
      sync_slot u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .hunt_write(wr_sync & config_bus_wdata[i]),
        .link_locked(link_locked[i]),
        .hunt_start(hunt_start[i]),
        .synced(synced[i])
      );
      port_flush_ctrl u_flush (
        .sync_send(sync_packet_send_select[i]),
        .not_synced(~synced[i]),
        .downstream_send_permission(downstream_send_permission[i]),
        .threshold_grant(threshold_grant[i]),
        .send_sync_packet(send_sync_packet[i]),
        .slow_flush(slow_flush[i]),
        .dequeue_allowed(dequeue_allowed[i]),
        .accept_input(accept_input[i]),
        .queue_grant(queue_grant[i])
      );
    end
  endgenerate
endmodule // switch_port_sync_and_irq_mask_regs
`default_nettype wire

// >>> testbench/link_align_model.sv
`default_nettype none
// ----------------------------------------
// Link alignment: relocks HUNT_CYC cycles after a hunt
// ----------------------------------------
module link_align_model #(parameter int HUNT_CYC = 8) (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire logic [15:0] hunt_start, // hunt pulses
  output logic [15:0] link_locked // aligned per port
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [16];
  always @(posedge core_clk) begin
    for (int p = 0; p < 16; p++) begin
      if (!rst_n || hunt_start[p]) cnt[p] <= HUNT_CYC;
      else if (cnt[p] != 0) cnt[p] <= cnt[p] - 1;
    end
  end
  always_comb for (int p = 0; p < 16; p++) link_locked[p] = (cnt[p] == 0);
endmodule // link_align_model
`default_nettype wire

// >>> testbench/port_regs_checker.sv
`include "port_regs_defs.vh"
`default_nettype none
module port_regs_checker #(parameter PORTS = 16) (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire logic clk_en, // enable
  input wire logic [5:0] config_bus_addr, // address
  input wire logic config_bus_wr, // write
  input wire logic config_bus_rd, // read
  input wire logic [15:0] config_bus_wdata, // wdata
  input wire logic [15:0] config_bus_rdata, // rdata
  input wire logic config_bus_rvalid, // rvalid
  input wire logic [15:0] app_status, // status
  input wire logic interrupt_out, // irq
  input wire logic [PORTS-1:0] hunt_start, // hunts
  input wire logic [PORTS-1:0] crc_error, // crc
  input wire logic [PORTS-1:0] send_sync_packet, // sync mode
  input wire logic [PORTS-1:0] slow_flush // flush
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence hunt_wr;
    config_bus_wr && clk_en && config_bus_addr == `ADDR_LINK_SYNC_STATUS_HUNT;
  endsequence
  sequence sync_rd;
    config_bus_rd && clk_en && config_bus_addr == `ADDR_LINK_SYNC_STATUS_HUNT;
  endsequence
  sequence crc_rd;
    config_bus_rd && clk_en && config_bus_addr == `ADDR_CRC_ERROR_PORT_FLAGS && crc_error == 0;
  endsequence
  a_irq_no_status: assert property (app_status == 0 |-> !interrupt_out)
    else $error("irq without status");
  a_hunt_pulse: assert property (hunt_wr |=> hunt_start == $past(config_bus_wdata))
    else $error("bad hunt");
  a_hunt_quiet: assert property (clk_en && !config_bus_wr |=> hunt_start == 0)
    else $error("stray hunt");
  a_read_valid: assert property (clk_en |=> config_bus_rvalid == $past(config_bus_rd)) else $error("rvalid");
  a_mask_reserved: assert property (clk_en && config_bus_rd && config_bus_addr == `ADDR_INTERRUPT_MASK
    |=> (config_bus_rdata & ~`MASK_WRITABLE) == 0) else $error("reserved mask bit");
  a_sync_flush: assert property ((send_sync_packet & ~slow_flush) == 0)
    else $error("no flush");
  a_crc_cleared: assert property (crc_rd ##1 crc_error == 0 ##1 crc_rd
    |=> config_bus_rdata == 0) else $error("crc not cleared");
  a_hunt_clears: assert property (hunt_wr ##2 sync_rd
    |=> (config_bus_rdata & $past(config_bus_wdata, 3)) == 0) else $error("sync kept");
endmodule // port_regs_checker
`default_nettype wire

// >>> testbench/switch_port_sync_and_irq_mask_regs_bench.sv
`include "port_regs_defs.vh"
`default_nettype none
module switch_port_sync_and_irq_mask_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] A_MSK = `ADDR_INTERRUPT_MASK;
  localparam logic [5:0] A_SYN = `ADDR_LINK_SYNC_STATUS_HUNT;
  localparam logic [5:0] A_CRC = `ADDR_CRC_ERROR_PORT_FLAGS;
  logic core_clk = 0, rst_n = 0, clk_en = 1, wr = 0, rd = 0, irq, rvalid;
  logic [5:0] addr = 0;
  logic [15:0] wdata = 0, rdata, app = 0, crc = 0, dsp = 0, thr = 0;
  logic [15:0] lock, hunt, sel, flush, deq, acc, grant;
  int err_count = 0, checked = 0;
  initial forever #10 core_clk = ~core_clk;
  switch_port_sync_and_irq_mask_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .config_bus_addr(addr), .config_bus_wr(wr), .config_bus_rd(rd), .config_bus_wdata(wdata),
    .config_bus_rdata(rdata), .config_bus_rvalid(rvalid), .app_status(app), .interrupt_out(irq),
    .link_locked(lock), .hunt_start(hunt), .crc_error(crc), .downstream_send_permission(dsp),
    .threshold_grant(thr), .send_sync_packet(sel), .slow_flush(flush), .dequeue_allowed(deq),
    .accept_input(acc), .queue_grant(grant));
  link_align_model i_link (.core_clk(core_clk), .rst_n(rst_n), .hunt_start(hunt), .link_locked(lock));
  task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus_wr(logic [5:0] a, logic [15:0] d);
    @(negedge core_clk) {wr, addr, wdata} = {1'b1, a, d};
    @(negedge core_clk) wr = 0;
  endtask
  task automatic rd_chk(string n, logic [5:0] a, logic [15:0] e);
    @(negedge core_clk) {rd, addr} = {1'b1, a};
    @(negedge core_clk) rd = 0;
    cmp("rvalid", 1, rvalid);
    cmp(n, e, rdata);
  endtask
  task automatic t_mask;
    rd_chk("mask reset", A_MSK, `RESET_INTERRUPT_MASK);
    bus_wr(A_MSK, 16'hFFFF);
    rd_chk("mask bits", A_MSK, `MASK_WRITABLE);
    for (int b = 0; b < 16; b++) begin
      app = 16'h0001 << b;
      bus_wr(A_MSK, app);
      cmp("irq masked", 0, irq);
      bus_wr(A_MSK, ~app);
      cmp("irq open", `MASK_WRITABLE >> b & 1, irq);
    end
    app = 0;
    $display("mask test done");
  endtask
  task automatic t_sync;
    rd_chk("sync all", A_SYN, 16'hFFFF);
    bus_wr(A_SYN, 16'h8009);
    cmp("hunt pulse", 16'h8009, hunt);
    rd_chk("sync hunt", A_SYN, 16'h7FF6);
    cmp("flush hunt", 16'h8009, flush);
    repeat (10) @(negedge core_clk);
    rd_chk("sync back", A_SYN, 16'hFFFF);
    dsp = 16'h00F0;
    thr = 16'hA5A5;
    bus_wr(`ADDR_SYNC_PACKET_SEND_SELECT, 16'h8001);
    rd_chk("select", `ADDR_SYNC_PACKET_SEND_SELECT, 16'h8001);
    cmp("sync pkt", 16'h8001, sel);
    cmp("flush sel", 16'h8001, flush);
    cmp("dequeue", 16'h80F1, deq);
    cmp("accept", 16'hFFFF, acc);
    cmp("grant", 16'hA5A5, grant);
    $display("sync test done");
  endtask
  task automatic t_crc;
    rd_chk("crc reset", A_CRC, `RESET_CRC_FLAGS);
    @(negedge core_clk) crc = 16'h8004;
    @(negedge core_clk) crc = 0;
    rd_chk("crc set", A_CRC, 16'h8004);
    rd_chk("crc clear", A_CRC, 0);
    @(negedge core_clk) {clk_en, crc} = {1'b0, 16'h0100};
    @(negedge core_clk) {clk_en, crc} = {1'b1, 16'h0000};
    rd_chk("crc frozen", A_CRC, 0);
    rd_chk("unmapped", 6'h3F, 0);
    $display("crc test done");
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rst_n = 1;
    repeat (12) @(negedge core_clk);
    t_mask;
    t_sync;
    t_crc;
    final_report;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    final_report;
  end
endmodule // switch_port_sync_and_irq_mask_regs_bench
bind switch_port_sync_and_irq_mask_regs port_regs_checker #(.PORTS(PORTS)) i_chk (.core_clk(core_clk),
  .rst_n(rst_n), .clk_en(clk_en), .config_bus_addr(config_bus_addr), .config_bus_wr(config_bus_wr),
  .config_bus_rd(config_bus_rd), .config_bus_wdata(config_bus_wdata), .config_bus_rdata(config_bus_rdata),
  .config_bus_rvalid(config_bus_rvalid), .app_status(app_status), .interrupt_out(interrupt_out),
  .hunt_start(hunt_start), .crc_error(crc_error), .send_sync_packet(send_sync_packet), .slow_flush(slow_flush));
`default_nettype wire
